/* src/trcc_top.v */
/*
  16-bit up-counting timer with shared reload/compare pair and a
  three-channel input capture unit, reached over classic wishbone.
  assumes: one clock, pins synchronous-safe via per-channel synchronisers,
  the interrupt controller outside consumes o_cap_irq and o_ovf_flag.
*/
`timescale 1ns/1ps
`include "trcc_consts.vh"

module trcc_top #(
  parameter ADR_W = 10,
  parameter NUM_PINS = `TRCC_NUM_PINS
) (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [ADR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire o_wb_ack,
  input wire [NUM_PINS-1:0] i_cap_pins,
  output wire o_cap_irq,
  output wire o_ovf_flag
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // terminal prescale count for each divider code
  function [8:0] div_term;
    input [2:0] code;
    begin
      case (code)
        3'h0: div_term = 9'h000;
        3'h1: div_term = 9'h003;
        3'h2: div_term = 9'h00F;
        3'h3: div_term = 9'h01F;
        3'h4: div_term = 9'h03F;
        3'h5: div_term = 9'h07F;
        3'h6: div_term = 9'h0FF;
        default: div_term = 9'h1FF;
      endcase
    end
  endfunction

  // pin multiplexer; unknown codes fall back to pin 0
  function pin_pick;
    input [NUM_PINS-1:0] pins;
    input [3:0] code;
    begin
      if (code < NUM_PINS)
        pin_pick = pins[code];
      else
        pin_pick = pins[0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg ack_ff;
  reg [7:0] rdat_ff;
  reg [7:0] nxt_rdat;
  reg flag_ff;
  reg run_ff;
  reg cmsel_ff;
  reg [7:0] mode_ff;
  reg [7:0] rc_low_ff;
  reg [7:0] rc_high_ff;
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg [8:0] pre_ff;
  reg [2:0] cap_en_ff;
  reg [2:0] cap_flag_ff;
  reg [5:0] edge_sel_ff;
  reg [2:0] filt_en_ff;
  reg [7:0] pinsel_a_ff;
  reg [3:0] pinsel_b_ff;
  reg ie_cap_ff;
  reg ie_glob_ff;
  reg irq_ff;
  reg [15:0] res0_ff;
  reg [15:0] res1_ff;
  reg [15:0] res2_ff;

  wire [7:0] idx = i_wb_adr[9:2];
  wire req = i_wb_cyc & i_wb_stb;
  wire wr = req & i_wb_we & ack_ff & i_wb_sel[0];
  wire [7:0] wd = i_wb_dat[7:0];
  wire [15:0] rc = {rc_high_ff, rc_low_ff};
  wire reload_enable = mode_ff[`TRCC_TM_RELOAD_ENABLE];
  wire [2:0] div_code = mode_ff[`TRCC_TM_DIV_HI:`TRCC_TM_DIV_LO];
  wire capclr = mode_ff[`TRCC_TM_CAPCLR];
  wire cmpclr = mode_ff[`TRCC_TM_CMPCLR];
  wire [1:0] trig = mode_ff[`TRCC_TM_TRIG_HI:`TRCC_TM_TRIG_LO];
  wire [2:0] cap_evt;
  wire [2:0] cap_pin;

  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  // ack one cycle after the request; writes land on the ack edge
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= `TRCC_RST_BYTE;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff)
        rdat_ff <= nxt_rdat;
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = {24'h000000, rdat_ff};

  // read decode; unmapped indices and reserved bits read zero
  always @*
  begin
    nxt_rdat = 8'h00;
    if (idx == `TRCC_IDX_TMR_CTRL)
      nxt_rdat = {flag_ff, 4'h0, run_ff, 1'b0, cmsel_ff};
    else if (idx == `TRCC_IDX_TMR_MODE)
      nxt_rdat = mode_ff;
    else if (idx == `TRCC_IDX_RC_LOW)
      nxt_rdat = rc_low_ff;
    else if (idx == `TRCC_IDX_RC_HIGH)
      nxt_rdat = rc_high_ff;
    else if (idx == `TRCC_IDX_CNT_LOW)
      nxt_rdat = cnt_ff[7:0];
    else if (idx == `TRCC_IDX_CNT_HIGH)
      nxt_rdat = cnt_ff[15:8];
    else if (idx == `TRCC_IDX_CAP_CTRL)
      nxt_rdat = {1'b0, cap_en_ff, 1'b0, cap_flag_ff};
    else if (idx == `TRCC_IDX_CAP_EDGE)
      nxt_rdat = {2'h0, edge_sel_ff};
    else if (idx == `TRCC_IDX_CAP_FILT)
      nxt_rdat = {1'b0, filt_en_ff, 4'h0};
    else if (idx == `TRCC_IDX_PINSEL_A)
      nxt_rdat = pinsel_a_ff;
    else if (idx == `TRCC_IDX_PINSEL_B)
      nxt_rdat = {4'h0, pinsel_b_ff};
    else if (idx == `TRCC_IDX_IRQ_EN)
      nxt_rdat = {ie_glob_ff, 4'h0, ie_cap_ff, 2'h0};
    else if (idx == `TRCC_IDX_CAP0_LOW)
      nxt_rdat = res0_ff[7:0];
    else if (idx == `TRCC_IDX_CAP0_HIGH)
      nxt_rdat = res0_ff[15:8];
    else if (idx == `TRCC_IDX_CAP1_LOW)
      nxt_rdat = res1_ff[7:0];
    else if (idx == `TRCC_IDX_CAP1_HIGH)
      nxt_rdat = res1_ff[15:8];
    else if (idx == `TRCC_IDX_CAP2_LOW)
      nxt_rdat = res2_ff[7:0];
    else if (idx == `TRCC_IDX_CAP2_HIGH)
      nxt_rdat = res2_ff[15:8];
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      run_ff <= 1'b0;
      cmsel_ff <= 1'b0;
      mode_ff <= `TRCC_RST_BYTE;
      rc_low_ff <= `TRCC_RST_BYTE;
      rc_high_ff <= `TRCC_RST_BYTE;
      cap_en_ff <= 3'h0;
      edge_sel_ff <= 6'h00;
      filt_en_ff <= 3'h0;
      pinsel_a_ff <= `TRCC_RST_BYTE;
      pinsel_b_ff <= 4'h0;
      ie_cap_ff <= 1'b0;
      ie_glob_ff <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == `TRCC_IDX_TMR_CTRL)
      begin
        run_ff <= wd[`TRCC_TC_RUN];
        cmsel_ff <= wd[`TRCC_TC_CMSEL];
      end
      else if (idx == `TRCC_IDX_TMR_MODE)
        mode_ff <= wd;
      else if (idx == `TRCC_IDX_RC_LOW)
        rc_low_ff <= wd;
      else if (idx == `TRCC_IDX_RC_HIGH)
        rc_high_ff <= wd;
      else if (idx == `TRCC_IDX_CAP_CTRL)
        cap_en_ff <= wd[`TRCC_CC_EN_LO+2:`TRCC_CC_EN_LO];
      else if (idx == `TRCC_IDX_CAP_EDGE)
        edge_sel_ff <= wd[5:0];
      else if (idx == `TRCC_IDX_CAP_FILT)
        filt_en_ff <= wd[`TRCC_CF_EN_LO+2:`TRCC_CF_EN_LO];
      else if (idx == `TRCC_IDX_PINSEL_A)
        pinsel_a_ff <= wd;
      else if (idx == `TRCC_IDX_PINSEL_B)
        pinsel_b_ff <= wd[3:0];
      else if (idx == `TRCC_IDX_IRQ_EN)
      begin
        ie_cap_ff <= wd[`TRCC_IE_CAP];
        ie_glob_ff <= wd[`TRCC_IE_GLOBAL];
      end
    end
  end

  // ----------------------------------------------------------------------
  // capture channels
  // ----------------------------------------------------------------------
  assign cap_pin[0] = pin_pick(i_cap_pins, pinsel_a_ff[3:0]);
  assign cap_pin[1] = pin_pick(i_cap_pins, pinsel_a_ff[7:4]);
  assign cap_pin[2] = pin_pick(i_cap_pins, pinsel_b_ff);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_chan
      trcc_cap_chan #(
        .FILT_CYCLES(`TRCC_FILT_CYCLES)
      ) u_chan (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_pin(cap_pin[gi]),
        .i_enable(cap_en_ff[gi]),
        .i_filt_en(filt_en_ff[gi]),
        .i_edge_sel(edge_sel_ff[2*gi+1:2*gi]),
        .o_evt(cap_evt[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // prescaler and counter events
  // ----------------------------------------------------------------------
  // prescale restarts while stopped so the first tick after run is clean
  wire tick = run_ff & (pre_ff >= div_term(div_code));
  wire ovf = tick & (cnt_ff == `TRCC_CNT_MAX);
  wire match = cmsel_ff & tick & (cnt_ff == rc);
  wire any_cap = |cap_evt;
  wire trig_cap = (trig != `TRCC_TRIG_OVF) & cap_evt[trig - 2'h1];

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pre_ff <= 9'h000;
    else if (!run_ff || tick)
      pre_ff <= 9'h000;
    else
      pre_ff <= pre_ff + 9'h001;
  end

  // later assignments override earlier ones, so clears and reloads beat
  // the increment; a bus byte write beats everything
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (tick)
      nxt_cnt = cnt_ff + 16'h0001;
    if (!cmsel_ff && reload_enable && trig == `TRCC_TRIG_OVF && ovf)
      nxt_cnt = rc;
    if (cmsel_ff && cmpclr && match)
      nxt_cnt = `TRCC_RST_WORD;
    if (!cmsel_ff && capclr && any_cap)
      nxt_cnt = `TRCC_RST_WORD;
    else if (!cmsel_ff && reload_enable && trig_cap)
      nxt_cnt = rc;
    if (wr && idx == `TRCC_IDX_CNT_LOW)
      nxt_cnt[7:0] = wd;
    if (wr && idx == `TRCC_IDX_CNT_HIGH)
      nxt_cnt[15:8] = wd;
  end

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_ff <= `TRCC_RST_WORD;
    else
      cnt_ff <= nxt_cnt;
  end

  // ----------------------------------------------------------------------
  // flags and capture results
  // ----------------------------------------------------------------------
  // a hardware set in the same cycle as a software clear wins
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      flag_ff <= 1'b0;
      cap_flag_ff <= 3'h0;
    end
    else
    begin
      flag_ff <= ((wr && idx == `TRCC_IDX_TMR_CTRL) ? wd[`TRCC_TC_FLAG] : flag_ff)
        | ovf | match;
      cap_flag_ff <= ((wr && idx == `TRCC_IDX_CAP_CTRL) ? wd[2:0] : cap_flag_ff)
        | cap_evt;
    end
  end

  // results take the count before any clear lands in the same cycle
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      res0_ff <= `TRCC_RST_WORD;
      res1_ff <= `TRCC_RST_WORD;
      res2_ff <= `TRCC_RST_WORD;
    end
    else
    begin
      if (cap_evt[0])
        res0_ff <= cnt_ff;
      else if (wr && idx == `TRCC_IDX_CAP0_LOW)
        res0_ff[7:0] <= wd;
      else if (wr && idx == `TRCC_IDX_CAP0_HIGH)
        res0_ff[15:8] <= wd;
      if (cap_evt[1])
        res1_ff <= cnt_ff;
      else if (wr && idx == `TRCC_IDX_CAP1_LOW)
        res1_ff[7:0] <= wd;
      else if (wr && idx == `TRCC_IDX_CAP1_HIGH)
        res1_ff[15:8] <= wd;
      if (cap_evt[2])
        res2_ff <= cnt_ff;
      else if (wr && idx == `TRCC_IDX_CAP2_LOW)
        res2_ff[7:0] <= wd;
      else if (wr && idx == `TRCC_IDX_CAP2_HIGH)
        res2_ff[15:8] <= wd;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_ff <= 1'b0;
    else
      irq_ff <= (|cap_flag_ff) & ie_cap_ff & ie_glob_ff;
  end

  assign o_cap_irq = irq_ff;
  assign o_ovf_flag = flag_ff;

endmodule

/* common/trcc_consts.vh */
/*
  register indices, field positions, reset values and counts for the
  16-bit reload/compare timer with three-channel input capture.
  assumes: included by bare name; each index maps to byte address 4*index.
*/
`ifndef TRCC_CONSTS_VH
`define TRCC_CONSTS_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define TRCC_IDX_CAP_CTRL 8'h92
`define TRCC_IDX_CAP_EDGE 8'h93
`define TRCC_IDX_CAP_FILT 8'h94
`define TRCC_IDX_TMR_CTRL 8'hC8
`define TRCC_IDX_TMR_MODE 8'hC9
`define TRCC_IDX_RC_LOW 8'hCA
`define TRCC_IDX_RC_HIGH 8'hCB
`define TRCC_IDX_CNT_LOW 8'hCC
`define TRCC_IDX_CNT_HIGH 8'hCD
`define TRCC_IDX_IRQ_EN 8'hD0
`define TRCC_IDX_CAP0_LOW 8'hE4
`define TRCC_IDX_CAP0_HIGH 8'hE5
`define TRCC_IDX_CAP1_LOW 8'hE6
`define TRCC_IDX_CAP1_HIGH 8'hE7
`define TRCC_IDX_CAP2_LOW 8'hED
`define TRCC_IDX_CAP2_HIGH 8'hEE
`define TRCC_IDX_PINSEL_A 8'hF1
`define TRCC_IDX_PINSEL_B 8'hF2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TRCC_TC_FLAG 7
`define TRCC_TC_RUN 2
`define TRCC_TC_CMSEL 0
`define TRCC_TM_RELOAD_ENABLE 7
`define TRCC_TM_DIV_HI 6
`define TRCC_TM_DIV_LO 4
`define TRCC_TM_CAPCLR 3
`define TRCC_TM_CMPCLR 2
`define TRCC_TM_TRIG_HI 1
`define TRCC_TM_TRIG_LO 0
`define TRCC_CC_EN_LO 4
`define TRCC_CF_EN_LO 4
`define TRCC_IE_CAP 2
`define TRCC_IE_GLOBAL 7

// ----------------------------------------------------------------------
// encodings, reset values, counts
// ----------------------------------------------------------------------
`define TRCC_EDGE_FALL 2'h0
`define TRCC_EDGE_RISE 2'h1
`define TRCC_EDGE_BOTH 2'h2
`define TRCC_TRIG_OVF 2'h0
`define TRCC_RST_BYTE 8'h00
`define TRCC_RST_WORD 16'h0000
`define TRCC_CNT_MAX 16'hFFFF
`define TRCC_FILT_CYCLES 4
`define TRCC_NUM_PINS 9

`endif

/* src/trcc_cap_chan.v */
/*
  one input capture channel: two-flop synchroniser, optional glitch
  filter and edge qualifier; emits a one-cycle registered event.
  assumes: the pin has already been selected by the caller's multiplexer.
*/
`timescale 1ns/1ps
`include "trcc_consts.vh"

module trcc_cap_chan #(
  parameter FILT_CYCLES = `TRCC_FILT_CYCLES
) (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_pin,
  input wire i_enable,
  input wire i_filt_en,
  input wire [1:0] i_edge_sel,
  output wire o_evt
);

  reg sync1_ff;
  reg sync2_ff;
  reg filt_ff;
  reg prev_ff;
  reg [2:0] stab_ff;
  reg evt_ff;
  reg nxt_evt;

  // ----------------------------------------------------------------------
  // synchroniser and filter
  // ----------------------------------------------------------------------
  // the first stage feeds only the second stage
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
      stab_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      prev_ff <= filt_ff;
      // a new level is accepted only once it has held for the full count
      if (!i_filt_en)
      begin
        filt_ff <= sync2_ff;
        stab_ff <= 3'h0;
      end
      else if (sync2_ff != filt_ff)
      begin
        if (stab_ff == FILT_CYCLES[2:0] - 3'h1)
        begin
          filt_ff <= sync2_ff;
          stab_ff <= 3'h0;
        end
        else
          stab_ff <= stab_ff + 3'h1;
      end
      else
        stab_ff <= 3'h0;
    end
  end

  // ----------------------------------------------------------------------
  // edge qualifier
  // ----------------------------------------------------------------------
  // reserved encoding never fires, so a stray config cannot capture
  always @*
  begin
    nxt_evt = 1'b0;
    case (i_edge_sel)
      `TRCC_EDGE_FALL: nxt_evt = prev_ff & ~filt_ff;
      `TRCC_EDGE_RISE: nxt_evt = ~prev_ff & filt_ff;
      `TRCC_EDGE_BOTH: nxt_evt = prev_ff ^ filt_ff;
      default: nxt_evt = 1'b0;
    endcase
    nxt_evt = nxt_evt & i_enable;
  end

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      evt_ff <= 1'b0;
    else
      evt_ff <= nxt_evt;
  end

  assign o_evt = evt_ff;

endmodule

/* test/trcc_top_chk.sv */
/*
  checker for trcc_top: bus handshake, read data and sticky outputs.
  assumes: bound to trcc_top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module trcc_top_chk #(
  parameter ADR_W = 10,
  parameter NUM_PINS = 9
) (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [ADR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire [NUM_PINS-1:0] i_cap_pins,
  input wire o_cap_irq,
  input wire o_ovf_flag
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic [4:0] quiet_ff;
  logic [NUM_PINS-1:0] pins_ff;
  wire req = i_wb_cyc && i_wb_stb;
  wire wr_done = o_wb_ack && i_wb_we;
  wire flag_clr = wr_done && i_wb_sel[0] && !i_wb_dat[7] && i_wb_adr[ADR_W-1:2] == 8'hC8;

  // cycles since a pin moved or a write landed; saturates so it never wraps
  always @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      quiet_ff <= 5'h1F;
      pins_ff <= '0;
    end
    else
    begin
      pins_ff <= i_cap_pins;
      if (pins_ff != i_cap_pins || wr_done)
        quiet_ff <= 5'h00;
      else if (quiet_ff != 5'h1F)
        quiet_ff <= quiet_ff + 5'h01;
    end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_ACK_ONE: assert property (req && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_NOREQ: assert property (!req |=> !o_wb_ack)
    else $error("ack without request");
  AST_DAT_HI: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_UNMAP: assert property (o_wb_ack && !i_wb_we && i_wb_adr[ADR_W-1:2] == 8'h00
    |-> o_wb_dat == 32'h00000000)
    else $error("unmapped read not zero");
  AST_FLAG_HOLD: assert property ($fell(o_ovf_flag)
    |-> $past(flag_clr) || $past(flag_clr, 2))
    else $error("overflow flag dropped without software clear");
  AST_CAPF_HOLD: assert property ($fell(o_cap_irq)
    |-> $past(wr_done) || $past(wr_done, 2))
    else $error("capture request dropped without a write");
  AST_IRQ_CAUSE: assert property ($rose(o_cap_irq) |-> quiet_ff < 5'd16)
    else $error("capture request without pin edge or write");

  COV_WRITE: cover property (wr_done);
  COV_IRQ: cover property ($rose(o_cap_irq));
  COV_FLAG: cover property ($rose(o_ovf_flag));
endmodule

bind trcc_top trcc_top_chk #(.ADR_W(ADR_W), .NUM_PINS(NUM_PINS)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cap_pins(i_cap_pins),
  .o_cap_irq(o_cap_irq), .o_ovf_flag(o_ovf_flag));

/* test/trcc_pin_model.sv */
/*
  source for the nine external capture pins.
  assumes: pins idle low and always driven; changes land after a rising edge.
*/
`timescale 1ns/1ps
module trcc_pin_model (
  input wire logic i_clk,
  output logic [8:0] o_pins
);
  initial o_pins = 9'h000;

  // step one pin just after an edge so the synchroniser sees a clean change
  task automatic drive(input int idx, input logic val);
    begin
      @(posedge i_clk);
      o_pins[idx] <= val;
    end
  endtask

  // high for a number of clocks, then low again
  task automatic pulse(input int idx, input int width);
    begin
      drive(idx, 1'b1);
      repeat (width) @(posedge i_clk);
      o_pins[idx] <= 1'b0;
    end
  endtask
endmodule

/* test/tb_trcc_top.sv */
/*
  self-checking bench for trcc_top: registers, timer modes, capture channels.
  assumes: trcc_pin_model drives the pins; the checker is bound separately.
*/
`timescale 1ns/1ps
`define CHK(g, e) chk(g, e)
module tb_trcc_top;
  logic clk;
  logic rstn;
  logic cyc;
  logic stb;
  logic we;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  wire [31:0] rdat;
  wire ack;
  wire [8:0] pins;
  wire irq;
  wire ovf;
  int mismatches;
  int cmp_count;

  trcc_top dut (.i_ref_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_cap_pins(pins), .o_cap_irq(irq), .o_ovf_flag(ovf));
  trcc_pin_model pm (.i_clk(clk), .o_pins(pins));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        mismatches++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    begin
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hF;
      wdat <= {24'h000000, d};
      do
      begin
        @(posedge clk);
        n++;
      end
      while (ack !== 1'b1 && n < 64);
      if (n >= 64)
      begin
        mismatches++;
        $display("[ERR] %0t bus request not acknowledged", $time);
      end
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    begin
      wb(1'b1, idx, d, x);
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    begin
      wb(1'b0, idx, 8'h00, r);
    end
  endtask

  // bounded wait on the overflow/match output
  task automatic wait_flag();
    int n;
    begin
      n = 0;
      while (ovf !== 1'b1 && n < 2000)
      begin
        @(posedge clk);
        n++;
      end
      `CHK(ovf, 1'b1);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] idx [5];
    logic [7:0] v;
    begin
      idx = '{8'h92, 8'h93, 8'hCB, 8'hCC, 8'hCD};
      foreach (idx[i])
      begin
        rd(idx[i], v);
        `CHK(v, 8'h00);
      end
      wr(8'hCB, 8'hA5);
      rd(8'hCB, v);
      `CHK(v, 8'hA5);
      wr(8'hCC, 8'h3C);
      wr(8'hCD, 8'hC3);
      rd(8'hCC, v);
      `CHK(v, 8'h3C);
      rd(8'hCD, v);
      `CHK(v, 8'hC3);
      wr(8'h00, 8'h5A);
      rd(8'h00, v);
      `CHK(v, 8'h00);
    end
  endtask

  // overflow reloads 0x1234 with the slowest prescale so the value stays put
  task automatic t_overflow();
    logic [7:0] v;
    begin
      wr(8'hCA, 8'h34);
      wr(8'hCB, 8'h12);
      wr(8'hCC, 8'hFF);
      wr(8'hCD, 8'hFF);
      wr(8'hC9, 8'hF0);
      wr(8'hC8, 8'h04);
      wait_flag();
      wr(8'hC8, 8'h80);
      rd(8'hCC, v);
      `CHK(v, 8'h34);
      rd(8'hCD, v);
      `CHK(v, 8'h12);
      wr(8'hC8, 8'h00);
      repeat (3) @(posedge clk);
      `CHK(ovf, 1'b0);
    end
  endtask

  // match at 0x0040 with clear: count stays far below the compare value
  task automatic t_compare();
    logic [7:0] v;
    begin
      wr(8'hCA, 8'h40);
      wr(8'hCB, 8'h00);
      wr(8'hCC, 8'h00);
      wr(8'hCD, 8'h00);
      wr(8'hC9, 8'h04);
      wr(8'hC8, 8'h05);
      wait_flag();
      wr(8'hC8, 8'h81);
      rd(8'hCD, v);
      `CHK(v, 8'h00);
      rd(8'hCC, v);
      `CHK(v < 8'h40, 1'b1);
      wr(8'hC8, 8'h00);
    end
  endtask

  // every channel with every edge code; timer halted at 0x4321
  task automatic t_capture();
    logic [7:0] v;
    logic [7:0] e;
    int pin_of [3];
    logic [7:0] res_lo [3];
    logic [7:0] res_hi [3];
    begin
      pin_of = '{2, 5, 8};
      res_lo = '{8'hE4, 8'hE6, 8'hED};
      res_hi = '{8'hE5, 8'hE7, 8'hEE};
      wr(8'hC9, 8'h00);
      wr(8'hCC, 8'h21);
      wr(8'hCD, 8'h43);
      wr(8'hF1, 8'h52);
      wr(8'hF2, 8'h08);
      wr(8'hD0, 8'h84);
      for (int ch = 0; ch < 3; ch++)
        for (int es = 0; es < 4; es++)
        begin
          wr(8'h93, (8'h3F & ~(8'h03 << (2 * ch))) | (8'(es) << (2 * ch)));
          wr(8'h92, 8'h70);
          wr(res_lo[ch], 8'h00);
          wr(res_hi[ch], 8'h00);
          pm.drive(pin_of[ch], 1'b1);
          repeat (12) @(posedge clk);
          rd(8'h92, v);
          `CHK(v[ch], (es == 1 || es == 2));
          pm.drive(pin_of[ch], 1'b0);
          repeat (12) @(posedge clk);
          e = (es == 3) ? 8'h70 : (8'h70 | (8'h01 << ch));
          rd(8'h92, v);
          `CHK(v, e);
          `CHK(irq, es != 3);
          rd(res_lo[ch], v);
          `CHK(v, (es == 3) ? 8'h00 : 8'h21);
          rd(res_hi[ch], v);
          `CHK(v, (es == 3) ? 8'h00 : 8'h43);
        end
    end
  endtask

  // a three-clock glitch is dropped, an eight-clock pulse gets through
  task automatic t_filter();
    logic [7:0] v;
    begin
      wr(8'h93, 8'h3D);
      wr(8'h94, 8'h10);
      wr(8'h92, 8'h70);
      pm.pulse(2, 3);
      repeat (16) @(posedge clk);
      rd(8'h92, v);
      `CHK(v, 8'h70);
      pm.pulse(2, 8);
      repeat (16) @(posedge clk);
      rd(8'h92, v);
      `CHK(v, 8'h71);
    end
  endtask

  // capture clears instead of reloading, then reloads once the clear is off
  task automatic t_capclr();
    logic [7:0] v;
    begin
      wr(8'h94, 8'h00);
      wr(8'hCC, 8'h00);
      wr(8'hCD, 8'h01);
      wr(8'hCA, 8'h54);
      wr(8'hCB, 8'h55);
      wr(8'hC9, 8'hF9);
      wr(8'hC8, 8'h04);
      pm.pulse(2, 4);
      repeat (12) @(posedge clk);
      wr(8'hC8, 8'h00);
      rd(8'hE5, v);
      `CHK(v, 8'h01);
      rd(8'hCD, v);
      `CHK(v, 8'h00);
      rd(8'hCC, v);
      `CHK(v[7:1], 7'h00);
      wr(8'hC9, 8'hF1);
      wr(8'hC8, 8'h04);
      pm.pulse(2, 4);
      repeat (12) @(posedge clk);
      wr(8'hC8, 8'h00);
      rd(8'hCD, v);
      `CHK(v, 8'h55);
      rd(8'hCC, v);
      `CHK(v[7:1], 7'h2A);
    end
  endtask

  // divide by four: the stop lands mid-period, so 24 ticks either way
  task automatic t_prescale();
    logic [7:0] v;
    begin
      wr(8'hCC, 8'h00);
      wr(8'hCD, 8'h00);
      wr(8'hC9, 8'h10);
      wr(8'hC8, 8'h04);
      repeat (95) @(posedge clk);
      wr(8'hC8, 8'h00);
      rd(8'hCC, v);
      `CHK(v, 8'h18);
      rd(8'hCD, v);
      `CHK(v, 8'h00);
    end
  endtask

  task automatic give_verdict();
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ------------------------------------------------------------
  // clock, sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    {rstn, cyc, stb, we} = 4'h0;
    {adr, sel, wdat} = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_overflow();
    t_compare();
    t_capture();
    t_filter();
    t_capclr();
    t_prescale();
    give_verdict();
  end

  // the whole sequence needs well under ten thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
